// file: verif/frame_source.sv
// far-end framer model: receive frame boundaries and signal energy
`timescale 1ns/1ns
`default_nettype none

module frame_source
(
    // clock
    input  wire logic ref_clk,
    // framed receive signal
    output logic      frame_strobe,
    output logic      sync_match,
    output logic      frame_alignment_changed,
    output logic      energy_detect
);
    initial
    begin
        frame_strobe = 1'b0;
        sync_match = 1'b0;
        frame_alignment_changed = 1'b0;
        energy_detect = 1'b1;
    end

    // raise a boundary and leave it up, so the next call can follow back to back
    task automatic frame_hold(input logic m, input logic s);
        @(negedge ref_clk);
        frame_strobe <= 1'b1;
        sync_match <= m;
        frame_alignment_changed <= s;
    endtask

    // close a run of frames; qualifiers inverted while no boundary
    task automatic frame_end();
        @(negedge ref_clk);
        frame_strobe <= 1'b0;
        sync_match <= ~sync_match;
        frame_alignment_changed <= ~frame_alignment_changed;
    endtask

    // one isolated boundary pulse
    task automatic frame(input logic m, input logic s);
        frame_hold(m, s);
        frame_end();
    endtask

    task automatic energy(input logic on);
        @(negedge ref_clk);
        energy_detect <= on;
    endtask
endmodule

`default_nettype wire

// file: verif/frame_sync_fsm_bench.sv
// testbench of the receive frame sync machine
`timescale 1ns/1ns
`default_nettype none

module frame_sync_fsm_bench;
    import frame_sync_pkg::*;

    logic        ref_clk;
    logic        rstn;
    logic [1:0]  rate_sel;
    wire logic   frame_strobe;
    wire logic   sync_match;
    wire logic   frame_alignment_changed;
    wire logic   energy_detect;
    sync_state_t sync_state;
    act_state_t  act_state;
    logic        in_sync;
    logic        timer_expired;
    int          n_mismatch = 0;
    int          check_count = 0;
    // short deactivation times so every rate expires within a few cycles
    localparam logic [31:0] CYC_SIM_272 = 32'd20;
    localparam logic [31:0] CYC_SIM_400 = 32'd16;
    localparam logic [31:0] CYC_SIM_528 = 32'd12;
    localparam logic [31:0] CYC_SIM_784 = 32'd8;
    int          n_tab[4] = '{CYC_SIM_272, CYC_SIM_400, CYC_SIM_528, CYC_SIM_784};

    frame_source FS (
        .ref_clk                 (ref_clk),
        .frame_strobe            (frame_strobe),
        .sync_match              (sync_match),
        .frame_alignment_changed (frame_alignment_changed),
        .energy_detect           (energy_detect)
    );

    frame_sync_fsm #(
        .DEACT_CYC_272 (CYC_SIM_272),
        .DEACT_CYC_400 (CYC_SIM_400),
        .DEACT_CYC_528 (CYC_SIM_528),
        .DEACT_CYC_784 (CYC_SIM_784)
    ) DUT (
        .ref_clk                 (ref_clk),
        .rstn                    (rstn),
        .frame_strobe            (frame_strobe),
        .sync_match              (sync_match),
        .frame_alignment_changed (frame_alignment_changed),
        .energy_detect           (energy_detect),
        .rate_sel                (rate_sel),
        .sync_state              (sync_state),
        .act_state               (act_state),
        .in_sync                 (in_sync),
        .timer_expired           (timer_expired)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic expect_st(input sync_state_t s, input act_state_t a);
        check("sync_state", sync_state, s);
        check("act_state", act_state, a);
        check("in_sync", in_sync, a == ACT_ACTIVE);
    endtask

    // match then miss while acquiring falls back to start
    task automatic acq_fail();
        expect_st(SYNC_OUT_INIT, ACT_INACTIVE);
        FS.frame(1'b0, 1'b0);
        expect_st(SYNC_OUT_INIT, ACT_INACTIVE);
        FS.frame(1'b1, 1'b0);
        FS.frame(1'b0, 1'b0);
        expect_st(SYNC_OUT_INIT, ACT_INACTIVE);
    endtask

    // two matches, back to back or with idle cycles between the frames
    task automatic acquire(input logic quick);
        if (quick)
        begin
            FS.frame_hold(1'b1, 1'b0);
            FS.frame_hold(1'b1, 1'b1);
            expect_st(SYNC_ACQ_ONE, ACT_ACTIVATING);
            FS.frame_end();
        end
        else
        begin
            FS.frame(1'b1, 1'b0);
            expect_st(SYNC_ACQ_ONE, ACT_ACTIVATING);
            repeat (3) @(negedge ref_clk);
            expect_st(SYNC_ACQ_ONE, ACT_ACTIVATING);
            FS.frame(1'b1, 1'b1);
        end
        expect_st(SYNC_LOCKED, ACT_ACTIVE);
    endtask

    // six misses; optionally a match after five resets the count
    task automatic lose(input logic probe);
        if (probe)
        begin
            repeat (5) FS.frame(1'b0, 1'b0);
            FS.frame(1'b1, 1'b0);
            expect_st(SYNC_LOCKED, ACT_ACTIVE);
        end
        // back-to-back misses; each check sees the frame before the one just raised
        for (int i = 0; i < 6; i++)
        begin
            FS.frame_hold(1'b0, 1'b0);
            if (i > 0)
                expect_st(sync_state_t'(4'(SYNC_MISS_1) + 4'(i - 1)), ACT_ACTIVE);
        end
        FS.frame_end();
        expect_st(SYNC_LOST, ACT_PENDING);
    endtask

    // two back-to-back matching frames out of loss of sync
    task automatic recover(input logic s);
        FS.frame_hold(1'b1, s);
        FS.frame_hold(1'b1, 1'b0);
        expect_st(s ? SYNC_RECOVER_SHIFT : SYNC_RECOVER_SAME, ACT_PENDING);
        FS.frame_end();
        expect_st(SYNC_LOCKED, ACT_ACTIVE);
    endtask

    // reset just after loss of sync, while the timer start is still pending
    task automatic reset_mid();
        rstn = 1'b0;
        @(negedge ref_clk);
        expect_st(SYNC_OUT_INIT, ACT_INACTIVE);
        check("timer_expired", timer_expired, 1'b0);
        rstn = 1'b1;
    endtask

    task automatic energy_drop();
        FS.frame(1'b0, 1'b0);
        expect_st(SYNC_LOST, ACT_PENDING);
        FS.frame(1'b1, 1'b0);
        expect_st(SYNC_RECOVER_SAME, ACT_PENDING);
        FS.energy(1'b0);
        @(negedge ref_clk);
        expect_st(SYNC_OUT_INIT, ACT_INACTIVE);
        FS.energy(1'b1);
    endtask

    // loss of sync, then wait for the deactivation timer of one rate
    task automatic expiry(input logic [1:0] r, input int n);
        int k;
        k = 0;
        rate_sel = r;
        acquire(1'b1);
        lose(1'b0);
        while (timer_expired !== 1'b1 && k < n + 4)
        begin
            @(negedge ref_clk);
            k++;
        end
        check("expiry_cycles", k >= n && k <= n + 2, 1'b1);
        expect_st(SYNC_OUT_INIT, ACT_INACTIVE);
        if (k >= n + 4)
            conclude();
    endtask

    initial
    begin
        rstn = 1'b0;
        rate_sel = 2'h0;
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        acq_fail();
        acquire(1'b0);
        lose(1'b1);
        recover(1'b0);
        lose(1'b0);
        recover(1'b1);
        lose(1'b0);
        reset_mid();
        acquire(1'b1);
        lose(1'b0);
        energy_drop();
        for (int r = 0; r < 4; r++)
            expiry(2'(r), n_tab[r]);
        conclude();
    end
endmodule

`default_nettype wire

// file: verilog/deact_timer.sv
// pending deactivation timer with per-rate duration
`timescale 1ns/1ns
`default_nettype none
`include "frame_sync_params.svh"

module deact_timer
    import frame_sync_pkg::*;
#(
    parameter logic [31:0] CYC_272 = `DEACT_MS_272 * `REF_CLK_KHZ,
    parameter logic [31:0] CYC_400 = `DEACT_MS_400 * `REF_CLK_KHZ,
    parameter logic [31:0] CYC_528 = `DEACT_MS_528 * `REF_CLK_KHZ,
    parameter logic [31:0] CYC_784 = `DEACT_MS_784 * `REF_CLK_KHZ
)
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // control
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [1:0] rate_sel,
    // status
    output logic            expired
);

    timer_t tm_reg;
    timer_t tm_next;
    logic [31:0] limit;

    always_comb
    begin
        unique case (rate_sel)
            `RATE_272: limit = CYC_272;
            `RATE_400: limit = CYC_400;
            `RATE_528: limit = CYC_528;
            `RATE_784: limit = CYC_784;
        endcase
    end

    always_comb
    begin
        tm_next = tm_reg;
        tm_next.expired = 1'b0;
        if (start)
        begin
            tm_next.run = 1'b1;
            tm_next.cnt = '0;
        end
        else if (stop)
        begin
            tm_next.run = 1'b0;
        end
        else if (tm_reg.run)
        begin
            if (tm_reg.cnt >= limit - 32'd1)
            begin
                tm_next.run     = 1'b0;
                tm_next.expired = 1'b1;
            end
            else
            begin
                tm_next.cnt = tm_reg.cnt + 32'd1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            tm_reg <= '0;
        else
            tm_reg <= tm_next;
    end

    assign expired = tm_reg.expired;

endmodule
`default_nettype wire

// file: verilog/frame_sync_fsm.sv
// receive frame synchronization state machine
`timescale 1ns/1ns
`default_nettype none
`include "frame_sync_params.svh"

// What this block does
// - State advances only on a received frame boundary, one compare per frame, except the drop from pending deactivation to initial.
// - Identical behaviour in master and slave role; no role input.
// - From initial state, two consecutive matches via an intermediate state declare in-sync.
// - Six consecutive mismatches from in-sync pass five states then declare out-of-sync.
// - Out-of-sync returns to initial on timer expiry or loss of receive energy.
// - Recovery without alignment change: two clean frames via own state back to in-sync.
// - Recovery with alignment change: two matches via separate state back to in-sync.
// - Sync states map to inactive, activating, active and pending deactivation.
// - Deactivation timer starts on loss of sync; 6, 4, 3 or 2 s by rate.
module frame_sync_fsm
    import frame_sync_pkg::*;
#(
    parameter logic [31:0] DEACT_CYC_272 = `DEACT_MS_272 * `REF_CLK_KHZ,
    parameter logic [31:0] DEACT_CYC_400 = `DEACT_MS_400 * `REF_CLK_KHZ,
    parameter logic [31:0] DEACT_CYC_528 = `DEACT_MS_528 * `REF_CLK_KHZ,
    parameter logic [31:0] DEACT_CYC_784 = `DEACT_MS_784 * `REF_CLK_KHZ
)
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // framer inputs
    input  wire logic       frame_strobe,
    input  wire logic       sync_match,
    input  wire logic       frame_alignment_changed,
    input  wire logic       energy_detect,
    // configuration
    input  wire logic [1:0] rate_sel,
    // status
    output sync_state_t     sync_state,
    output act_state_t      act_state,
    output logic            in_sync,
    output logic            timer_expired
);

    fsm_t fsm_reg;
    fsm_t fsm_next;
    logic expired;

    function automatic act_state_t act_of(input sync_state_t s);
        unique case (s)
            SYNC_OUT_INIT:                          act_of = ACT_INACTIVE;
            SYNC_ACQ_ONE:                           act_of = ACT_ACTIVATING;
            SYNC_LOCKED, SYNC_MISS_1, SYNC_MISS_2,
            SYNC_MISS_3, SYNC_MISS_4, SYNC_MISS_5:  act_of = ACT_ACTIVE;
            default:                                act_of = ACT_PENDING;
        endcase
    endfunction

    function automatic logic is_pending(input sync_state_t s);
        is_pending = (s == SYNC_LOST) || (s == SYNC_RECOVER_SAME)
                  || (s == SYNC_RECOVER_SHIFT);
    endfunction

    deact_timer #(
        .CYC_272 (DEACT_CYC_272),
        .CYC_400 (DEACT_CYC_400),
        .CYC_528 (DEACT_CYC_528),
        .CYC_784 (DEACT_CYC_784)
    ) u_timer (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .start    (fsm_reg.timer_start),
        .stop     (fsm_reg.timer_stop),
        .rate_sel (rate_sel),
        .expired  (expired)
    );

    // no role input: master and slave share this path
    always_comb
    begin
        sync_state_t s;
        s = fsm_reg.st;
        fsm_next = fsm_reg;
        fsm_next.timer_start = 1'b0;
        fsm_next.timer_stop  = 1'b0;
        if (is_pending(s) && (expired || !energy_detect))
        begin
            s = SYNC_OUT_INIT;
        end
        else if (frame_strobe)
        begin
            unique case (s)
                SYNC_OUT_INIT:
                    s = sync_match ? SYNC_ACQ_ONE : SYNC_OUT_INIT;
                SYNC_ACQ_ONE:
                    s = sync_match ? SYNC_LOCKED : SYNC_OUT_INIT;
                SYNC_LOCKED:
                    s = sync_match ? SYNC_LOCKED : SYNC_MISS_1;
                SYNC_MISS_1:
                    s = sync_match ? SYNC_LOCKED : SYNC_MISS_2;
                SYNC_MISS_2:
                    s = sync_match ? SYNC_LOCKED : SYNC_MISS_3;
                SYNC_MISS_3:
                    s = sync_match ? SYNC_LOCKED : SYNC_MISS_4;
                SYNC_MISS_4:
                    s = sync_match ? SYNC_LOCKED : SYNC_MISS_5;
                SYNC_MISS_5:
                begin
                    s = sync_match ? SYNC_LOCKED : SYNC_LOST;
                    fsm_next.timer_start = !sync_match;
                end
                SYNC_LOST:
                begin
                    if (sync_match && frame_alignment_changed)
                        s = SYNC_RECOVER_SHIFT;
                    else if (sync_match)
                        s = SYNC_RECOVER_SAME;
                end
                SYNC_RECOVER_SAME:
                    s = (sync_match && !frame_alignment_changed)
                        ? SYNC_LOCKED : SYNC_LOST;
                SYNC_RECOVER_SHIFT:
                    s = sync_match ? SYNC_LOCKED : SYNC_LOST;
                default:
                    s = SYNC_OUT_INIT;
            endcase
        end
        // leaving pending deactivation halts the timer
        if (is_pending(fsm_reg.st) && !is_pending(s))
            fsm_next.timer_stop = 1'b1;
        fsm_next.st      = s;
        fsm_next.act     = act_of(s);
        fsm_next.in_sync = (act_of(s) == ACT_ACTIVE);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            fsm_reg <= '0;
        else
            fsm_reg <= fsm_next;
    end

    logic expired_reg;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            expired_reg <= 1'b0;
        else
            expired_reg <= expired;
    end

    assign sync_state    = fsm_reg.st;
    assign act_state     = fsm_reg.act;
    assign in_sync       = fsm_reg.in_sync;
    assign timer_expired = expired_reg;

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_match;
        frame_strobe && sync_match;
    endsequence

    sequence s_miss;
        frame_strobe && !sync_match;
    endsequence

    sequence s_stay_live;
        !(is_pending(sync_state) && (expired || !energy_detect));
    endsequence

    sequence s_timer_end;
        expired && is_pending(sync_state);
    endsequence

    a_frame_only_advance: assert property (
        !frame_strobe ##0 s_stay_live |=> $stable(sync_state))
        else $error("state moved without a frame");
    a_two_match_lock: assert property (
        sync_state == SYNC_OUT_INIT ##0 s_match ##1 s_match |=> in_sync)
        else $error("two matches did not lock");
    a_acq_miss_back: assert property (
        sync_state == SYNC_ACQ_ONE ##0 s_miss |=> sync_state == SYNC_OUT_INIT)
        else $error("miss in acquisition did not return to initial");
    a_six_miss_lost: assert property (
        sync_state == SYNC_LOCKED ##0 s_miss
        ##1 (s_stay_live and s_miss) ##1 s_miss ##1 s_miss ##1 s_miss ##1 s_miss
        |=> sync_state == SYNC_LOST && act_state == ACT_PENDING)
        else $error("six misses did not declare loss");
    a_miss_match_lock: assert property (
        sync_state inside {[SYNC_MISS_1:SYNC_MISS_5]} ##0 s_match
        |=> sync_state == SYNC_LOCKED)
        else $error("match while counting misses did not relock");
    a_loss_timer_go: assert property (
        sync_state == SYNC_MISS_5 ##0 s_miss |=> fsm_reg.timer_start)
        else $error("timer not started on loss");
    a_pending_drop: assert property (
        is_pending(sync_state) && (expired || !energy_detect)
        |=> sync_state == SYNC_OUT_INIT && act_state == ACT_INACTIVE)
        else $error("pending state did not drop to initial");
    a_recover_same: assert property (
        sync_state == SYNC_LOST ##0 (s_match and s_stay_live) ##0 !frame_alignment_changed
        ##1 (s_match and s_stay_live) ##0 !frame_alignment_changed
        |=> sync_state == SYNC_LOCKED)
        else $error("recovery without shift failed");
    a_recover_shift: assert property (
        sync_state == SYNC_LOST ##0 (s_match and s_stay_live) ##0 frame_alignment_changed
        |=> sync_state == SYNC_RECOVER_SHIFT)
        else $error("shift recovery state not entered");
    a_act_map: assert property (
        (sync_state == SYNC_ACQ_ONE) == (act_state == ACT_ACTIVATING))
        else $error("activating class mismatch");
    a_pending_class: assert property (
        sync_state inside {SYNC_LOST, SYNC_RECOVER_SAME, SYNC_RECOVER_SHIFT}
        |-> act_state == ACT_PENDING && !in_sync)
        else $error("pending class mismatch");
    a_init_idle: assert property (
        sync_state == SYNC_OUT_INIT ##0 s_miss |=> sync_state == SYNC_OUT_INIT)
        else $error("miss in initial state moved the machine");
    a_shift_relock: assert property (
        sync_state == SYNC_RECOVER_SHIFT ##0 (s_match and s_stay_live)
        |=> sync_state == SYNC_LOCKED)
        else $error("second match after shift did not relock");
    a_lost_wait: assert property (
        sync_state == SYNC_LOST ##0 (s_miss and s_stay_live) |=> sync_state == SYNC_LOST)
        else $error("miss while out of sync left the lost state");
    a_expiry_pulse: assert property (
        s_timer_end |=> timer_expired && sync_state == SYNC_OUT_INIT)
        else $error("timer expiry not reported with return to initial");

endmodule
`default_nettype wire

// file: verilog/frame_sync_params.svh
// constants of the receive frame sync machine
`ifndef FRAME_SYNC_PARAMS_SVH
`define FRAME_SYNC_PARAMS_SVH

// reference clock rate in kHz (250 MHz)
`define REF_CLK_KHZ      32'd250000

// nominal pending deactivation times in milliseconds, per line rate
`define DEACT_MS_272     32'd6000
`define DEACT_MS_400     32'd4000
`define DEACT_MS_528     32'd3000
`define DEACT_MS_784     32'd2000

// line rate select codes
`define RATE_272         2'h0
`define RATE_400         2'h1
`define RATE_528         2'h2
`define RATE_784         2'h3

// timer counter width
`define TIMER_W          32

`endif

// file: verilog/frame_sync_pkg.sv
// types of the receive frame sync machine
package frame_sync_pkg;

    typedef enum logic [3:0] {
        SYNC_OUT_INIT,
        SYNC_ACQ_ONE,
        SYNC_LOCKED,
        SYNC_MISS_1,
        SYNC_MISS_2,
        SYNC_MISS_3,
        SYNC_MISS_4,
        SYNC_MISS_5,
        SYNC_LOST,
        SYNC_RECOVER_SAME,
        SYNC_RECOVER_SHIFT
    } sync_state_t;

    typedef enum logic [1:0] {
        ACT_INACTIVE,
        ACT_ACTIVATING,
        ACT_ACTIVE,
        ACT_PENDING
    } act_state_t;

    typedef struct packed {
        sync_state_t st;
        act_state_t  act;
        logic        in_sync;
        logic        timer_start;
        logic        timer_stop;
    } fsm_t;

    typedef struct packed {
        logic        run;
        logic [31:0] cnt;
        logic        expired;
    } timer_t;

endpackage
